// ==== logic/accsc_pkg.sv ====
package accsc_pkg;

    localparam int unsigned CLK_PERIOD_PS = 8000;
    localparam int unsigned US_CYC = 1000000 / CLK_PERIOD_PS;

    // register map, serial-port addresses
    localparam logic [6:0] ADR_CHIP_IDENTIFIER = 7'h00;
    localparam logic [6:0] ADR_REV_ID = 7'h01;
    localparam logic [6:0] ADR_ACC_X = 7'h02;
    localparam logic [6:0] ADR_ACC_Z = 7'h04;
    localparam logic [6:0] ADR_CFG_LO = 7'h05;
    localparam logic [6:0] ADR_CFG_HI = 7'h0a;
    localparam logic [6:0] ADR_IRQ_INFO = 7'h0b;
    localparam logic [6:0] ADR_IRQ_TYPE = 7'h0c;
    localparam logic [6:0] ADR_ENG_EN = 7'h0d;
    localparam logic [6:0] ADR_IRQ_CTL = 7'h0e;
    localparam logic [6:0] ADR_AXIS_SLEEP = 7'h0f;
    localparam logic [6:0] ADR_FILTER = 7'h10;
    localparam logic [6:0] ADR_RANGE = 7'h11;
    localparam logic [6:0] ADR_SUSPEND = 7'h18;
    localparam logic [6:0] ADR_SOFT_RESET = 7'h19;

    // values after reset
    localparam logic [7:0] RST_AXIS_SLEEP = 8'h07;
    localparam logic [7:0] RST_FILTER = 8'h00;
    localparam logic [7:0] RST_RANGE = 8'h00;
    localparam logic [7:0] RST_ENG_EN = 8'h00;
    localparam logic [6:0] RST_IRQ_CTL = 7'h00;
    localparam logic [47:0] RST_CFG = 48'h08_45_b5_7f_4e_7f;

    // field positions
    localparam int unsigned SLEEP_EN_BIT = 6;
    localparam int unsigned SLEEP_DUR_LSB = 3;
    localparam int unsigned RAW_SEL_BIT = 7;
    localparam int unsigned IRQ_RESET_BIT = 7;
    localparam int unsigned LAT_LSB = 4;

    localparam logic [7:0] RD_ACTIVE = 8'hff;
    localparam logic [7:0] RD_IDLE = 8'h00;
    localparam logic [2:0] LAT_NONE = 3'b000;
    localparam logic [2:0] LAT_PERM = 3'b111;
    localparam logic [3:0] FILT_MAX_CODE = 4'h5;

    // times in microseconds
    localparam logic [23:0] SLEEP_US [8] = '{24'd2000, 24'd10000, 24'd25000, 24'd50000,
        24'd100000, 24'd500000, 24'd1000000, 24'd2000000};
    localparam logic [23:0] SETTLE_US [6] = '{24'd940, 24'd1440, 24'd2440, 24'd4440,
        24'd8440, 24'd16440};
    localparam logic [23:0] LATCH_US [8] = '{24'd0, 24'd250000, 24'd500000, 24'd1000000,
        24'd2000000, 24'd4000000, 24'd8000000, 24'd0};

    typedef enum logic [1:0] {
        PM_SLEEP = 2'b00,
        PM_WAKE = 2'b01,
        PM_EVAL = 2'b11,
        PM_NORMAL = 2'b10
    } accsc_pm_t;

    typedef struct packed {
        logic rd;
        logic wr;
        logic burst;
        logic [6:0] addr;
        logic [7:0] wdata;
    } accsc_req_t;

    // acc[2] = x, acc[1] = y, acc[0] = z, 6-bit two's complement
    typedef struct packed {
        logic valid;
        logic [2:0][5:0] acc;
    } accsc_smp_t;

    typedef struct packed {
        logic [7:0] us_div;
        accsc_pm_t pm;
        logic [23:0] pm_cnt;
        logic evald;
        logic [23:0] lat_cnt;
        logic lat_run;
        logic int_pin;
        logic raw_prev;
        logic [5:0] irq_type;
        logic [7:0] irq_info;
        logic suspend;
        logic softrst;
        logic [7:0] axis_sleep;
        logic [7:0] filter;
        logic [7:0] range;
        logic [7:0] eng_en;
        logic [6:0] irq_ctl;
        logic [47:0] cfg;
        logic [2:0][5:0] raw;
        logic [2:0][11:0] flt;
        logic [6:0] last_addr;
        logic [7:0] rdata;
        logic rvalid;
        logic analog_on;
        logic ic_on;
        accsc_smp_t filt_out;
    } accsc_state_t;

endpackage

// ==== logic/accsc_core.sv ====
module accsc_core
    import accsc_pkg::*;
#(
    parameter int unsigned CYC_PER_US = US_CYC,
    parameter logic [7:0] CHIP_IDENTIFIER_VAL = 8'h5a, // arbitrary value
    parameter logic [7:0] REV_ID_VAL = 8'h3c // arbitrary value
) (
    input wire logic core_clk,
    input wire logic reset,
    input wire accsc_req_t req,
    input wire accsc_smp_t smp,
    input wire logic [5:0] irq_cond,
    input wire logic [2:0] irq_first,
    input wire logic irq_sign,
    input wire logic [2:0] orient_code,
    output logic [7:0] rdata_q,
    output logic rvalid_q,
    output logic int_pin_q,
    output logic analog_on_q,
    output logic ic_on_q,
    output logic [2:0] axis_en_q,
    output logic [1:0] range_q,
    output logic [11:0] eng_en_q,
    output logic [47:0] eng_cfg_q,
    output accsc_smp_t filt_q
);

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic accsc_state_t rst_val();
        accsc_state_t r;
        r = '0;
        r.pm = PM_NORMAL;
        r.axis_sleep = RST_AXIS_SLEEP;
        r.filter = RST_FILTER;
        r.range = RST_RANGE;
        r.eng_en = RST_ENG_EN;
        r.irq_ctl = RST_IRQ_CTL;
        r.cfg = RST_CFG;
        r.analog_on = 1'b1;
        r.ic_on = 1'b1;
        return r;
    endfunction

    // out-of-range filter codes fall back to the 1kHz setting
    function automatic logic [2:0] filt_code(input logic [7:0] f);
        if (f[3:0] > FILT_MAX_CODE) begin
            return 3'h0;
        end
        return f[2:0];
    endfunction

    function automatic logic [7:0] rd_mux(input accsc_state_t st, input logic [6:0] a);
        logic [5:0] v;
        logic [6:0] idx;
        v = '0;
        idx = '0;
        if (a >= ADR_ACC_X && a <= ADR_ACC_Z) begin
            idx = 7'(a - ADR_ACC_X);
            if (st.filter[RAW_SEL_BIT]) begin
                v = st.raw[2 - idx[1:0]];
            end else begin
                v = st.flt[2 - idx[1:0]][11:6];
            end
            return {v, 2'b00};
        end
        if (a >= ADR_CFG_LO && a <= ADR_CFG_HI) begin
            idx = 7'(a - ADR_CFG_LO);
            return st.cfg[idx[2:0] * 8 +: 8];
        end
        case (a)
            ADR_CHIP_IDENTIFIER: return CHIP_IDENTIFIER_VAL;
            ADR_REV_ID: return REV_ID_VAL;
            ADR_IRQ_INFO: return st.irq_info;
            ADR_IRQ_TYPE: return {3'b000, st.irq_type[4:0]};
            ADR_ENG_EN: return st.eng_en;
            ADR_IRQ_CTL: return {1'b0, st.irq_ctl};
            ADR_AXIS_SLEEP: return st.axis_sleep;
            ADR_FILTER: return st.filter;
            ADR_RANGE: return st.range;
            ADR_SUSPEND: return st.suspend ? RD_ACTIVE : RD_IDLE;
            ADR_SOFT_RESET: return st.softrst ? RD_ACTIVE : RD_IDLE;
            default: return 8'h00;
        endcase
    endfunction

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    accsc_state_t s_q;
    accsc_state_t s_d;

    always_comb begin
        logic tick;
        logic [6:0] a;
        logic irq_clr;
        logic raw_irq;
        logic raw_rise;
        logic [2:0] lat;
        logic sleep_en;
        logic [2:0] dur;
        logic [2:0] fsel;
        logic signed [12:0] diff;
        logic signed [12:0] step;
        accsc_state_t r;
        tick = 1'b0;
        a = '0;
        irq_clr = 1'b0;
        raw_irq = 1'b0;
        raw_rise = 1'b0;
        lat = '0;
        sleep_en = 1'b0;
        dur = '0;
        fsel = '0;
        diff = '0;
        step = '0;
        r = rst_val();
        s_d = s_q;
        s_d.rvalid = 1'b0;
        s_d.filt_out.valid = 1'b0;

        // --------------------------------------------------------
        // microsecond enable
        // --------------------------------------------------------
        if (s_q.us_div == 8'(CYC_PER_US - 1)) begin
            tick = 1'b1;
            s_d.us_div = '0;
        end else begin
            s_d.us_div = s_q.us_div + 8'h01;
        end

        // --------------------------------------------------------
        // register access
        // --------------------------------------------------------
        a = req.burst ? s_q.last_addr + 7'h01 : req.addr;
        if (req.rd || req.wr) begin
            s_d.last_addr = a;
        end
        if (req.rd) begin
            s_d.rdata = rd_mux(s_q, a);
            s_d.rvalid = 1'b1;
            if (a == ADR_SUSPEND) begin
                s_d.suspend = ~s_q.suspend;
            end
            if (a == ADR_SOFT_RESET) begin
                s_d.softrst = ~s_q.softrst;
            end
        end
        // writes are dropped while suspended or in soft reset
        if (req.wr && !s_q.suspend && !s_q.softrst) begin
            if (a >= ADR_CFG_LO && a <= ADR_CFG_HI) begin
                s_d.cfg[3'(a - ADR_CFG_LO) * 8 +: 8] = req.wdata;
            end
            case (a)
                ADR_ENG_EN: s_d.eng_en = req.wdata;
                ADR_IRQ_CTL: begin
                    s_d.irq_ctl = req.wdata[6:0];
                    irq_clr = req.wdata[IRQ_RESET_BIT];
                end
                ADR_AXIS_SLEEP: s_d.axis_sleep = req.wdata;
                ADR_FILTER: s_d.filter = req.wdata;
                ADR_RANGE: s_d.range = req.wdata;
                default: ;
            endcase
        end

        // --------------------------------------------------------
        // sample path and filter
        // --------------------------------------------------------
        fsel = filt_code(s_q.filter);
        if (smp.valid && s_q.analog_on) begin
            s_d.filt_out.valid = 1'b1;
            for (int i = 0; i < 3; i++) begin
                if (s_q.axis_sleep[i]) begin
                    s_d.raw[i] = smp.acc[i];
                    diff = $signed({smp.acc[i][5], smp.acc[i], 6'h00})
                        - $signed({s_q.flt[i][11], s_q.flt[i]});
                    step = diff >>> fsel;
                    s_d.flt[i] = s_q.flt[i] + step[11:0];
                end
                s_d.filt_out.acc[i] = s_d.flt[i][11:6];
            end
        end

        // --------------------------------------------------------
        // interrupt front end
        // --------------------------------------------------------
        lat = s_q.irq_ctl[LAT_LSB +: 3];
        raw_irq = s_q.ic_on && (|irq_cond);
        raw_rise = raw_irq && !s_q.raw_prev;
        s_d.raw_prev = raw_irq;
        // a new condition wins over a clear in the same cycle
        s_d.irq_type = ((irq_clr || lat == LAT_NONE) ? 6'h00 : s_q.irq_type)
            | (raw_irq ? irq_cond : 6'h00);
        if (raw_rise) begin
            s_d.irq_info = {irq_cond[5], orient_code, irq_first, irq_sign};
        end else if (irq_clr) begin
            s_d.irq_info = '0;
        end
        if (lat == LAT_NONE) begin
            s_d.int_pin = raw_irq;
            s_d.lat_run = 1'b0;
        end else if (lat == LAT_PERM) begin
            s_d.int_pin = raw_irq || (s_q.int_pin && !irq_clr);
            s_d.lat_run = 1'b0;
        end else begin
            if (irq_clr) begin
                s_d.int_pin = 1'b0;
                s_d.lat_run = 1'b0;
            end
            if (raw_rise) begin
                s_d.int_pin = 1'b1;
                s_d.lat_run = 1'b1;
                s_d.lat_cnt = LATCH_US[lat];
            end else if (s_q.lat_run && !irq_clr && tick) begin
                if (s_q.lat_cnt == 24'h0) begin
                    s_d.int_pin = 1'b0;
                    s_d.lat_run = 1'b0;
                end else begin
                    s_d.lat_cnt = s_q.lat_cnt - 24'h1;
                end
            end
        end

        // --------------------------------------------------------
        // power manager
        // --------------------------------------------------------
        sleep_en = s_q.axis_sleep[SLEEP_EN_BIT];
        dur = s_q.axis_sleep[SLEEP_DUR_LSB +: 3];
        if (!s_q.suspend) begin
            case (s_q.pm)
                PM_NORMAL: begin
                    if (sleep_en) begin
                        s_d.pm = PM_SLEEP;
                        s_d.pm_cnt = SLEEP_US[dur];
                    end
                end
                PM_SLEEP: begin
                    if (!sleep_en) begin
                        s_d.pm = PM_NORMAL;
                    end else if (tick) begin
                        if (s_q.pm_cnt == 24'h0) begin
                            s_d.pm = PM_WAKE;
                            s_d.pm_cnt = SETTLE_US[fsel];
                        end else begin
                            s_d.pm_cnt = s_q.pm_cnt - 24'h1;
                        end
                    end
                end
                PM_WAKE: begin
                    if (!sleep_en) begin
                        s_d.pm = PM_NORMAL;
                    end else if (tick) begin
                        if (s_q.pm_cnt == 24'h0) begin
                            s_d.pm = PM_EVAL;
                            s_d.evald = 1'b0;
                        end else begin
                            s_d.pm_cnt = s_q.pm_cnt - 24'h1;
                        end
                    end
                end
                PM_EVAL: begin
                    if (smp.valid) begin
                        s_d.evald = 1'b1;
                    end
                    if (!sleep_en) begin
                        s_d.pm = PM_NORMAL;
                    end else if (s_q.evald && !raw_irq && !s_q.int_pin) begin
                        s_d.pm = PM_SLEEP;
                        s_d.pm_cnt = SLEEP_US[dur];
                    end
                end
                default: s_d.pm = PM_NORMAL;
            endcase
        end

        // --------------------------------------------------------
        // soft reset restores every written host setting; the suspend toggle keeps its state
        // --------------------------------------------------------
        if (s_d.softrst) begin
            s_d.pm = r.pm;
            s_d.pm_cnt = r.pm_cnt;
            s_d.axis_sleep = r.axis_sleep;
            s_d.filter = r.filter;
            s_d.range = r.range;
            s_d.eng_en = r.eng_en;
            s_d.irq_ctl = r.irq_ctl;
            s_d.cfg = r.cfg;
            s_d.int_pin = 1'b0;
            s_d.lat_run = 1'b0;
            s_d.irq_type = '0;
            s_d.irq_info = '0;
            s_d.raw = '0;
            s_d.flt = '0;
        end
        s_d.analog_on = !s_d.suspend && !s_d.softrst && (s_d.pm != PM_SLEEP);
        s_d.ic_on = !s_d.suspend && !s_d.softrst
            && (s_d.pm == PM_NORMAL || s_d.pm == PM_EVAL);
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            s_q <= rst_val();
        end else begin
            s_q <= s_d;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign rdata_q = s_q.rdata;
    assign rvalid_q = s_q.rvalid;
    assign int_pin_q = s_q.int_pin;
    assign analog_on_q = s_q.analog_on;
    assign ic_on_q = s_q.ic_on;
    assign axis_en_q = s_q.axis_sleep[2:0];
    assign range_q = s_q.range[1:0];
    assign eng_en_q = {s_q.irq_ctl[3:0], s_q.eng_en};
    assign eng_cfg_q = s_q.cfg;
    assign filt_q = s_q.filt_out;

endmodule

// ==== verification/accsc_core_props.sv ====
module accsc_core_props
    import accsc_pkg::*;
(
    input wire logic core_clk,
    input wire logic reset,
    input wire accsc_req_t req,
    input wire accsc_smp_t smp,
    input wire logic [5:0] irq_cond,
    input wire logic [7:0] rdata_q,
    input wire logic rvalid_q,
    input wire logic int_pin_q,
    input wire logic analog_on_q,
    input wire logic ic_on_q,
    input wire logic [2:0] axis_en_q,
    input wire logic [1:0] range_q,
    input wire logic [47:0] eng_cfg_q,
    input wire accsc_smp_t filt_q
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);
    // ----
    // latch mode as last written
    // ----
    logic [2:0] lat_q;
    logic ctl_wr;
    logic took_q;
    // a sample accepted at this edge must show as a filtered pulse at the next
    always_ff @(posedge core_clk) begin
        if (reset) begin
            took_q <= 1'b0;
        end else begin
            took_q <= smp.valid && analog_on_q;
        end
    end
    assign ctl_wr = req.wr && !req.burst && req.addr == ADR_IRQ_CTL;
    always_ff @(posedge core_clk) begin
        if (reset) begin
            lat_q <= LAT_NONE;
        end else if (ctl_wr) begin
            lat_q <= req.wdata[6:4];
        end
    end
    burst_answer_a: assert property (req.rd && req.burst |=> rvalid_q)
        else $error("burst read not answered");
    susp_enter_a: assert property (
        (req.rd && !req.burst && req.addr == ADR_SUSPEND) ##1 (rdata_q == RD_IDLE)
        |-> !analog_on_q && !ic_on_q) else $error("suspend not entered");
    sreset_cfg_a: assert property (
        (req.rd && !req.burst && req.addr == ADR_SOFT_RESET) ##1 (rdata_q == RD_IDLE)
        |-> ##[0:1] axis_en_q == 3'b111 && range_q == 2'b00 && eng_cfg_q == RST_CFG
        && !int_pin_q) else $error("config kept in soft reset");
    filt_pulse_a: assert property (filt_q.valid == took_q)
        else $error("filtered pulse wrong");
    axis_hold_a: assert property (
        smp.valid && analog_on_q && !axis_en_q[2] |=> $stable(filt_q.acc[2]))
        else $error("disabled axis changed");
    int_set_a: assert property (ic_on_q && irq_cond != 6'h00 |=> int_pin_q)
        else $error("interrupt not raised");
    unlatch_a: assert property (lat_q == LAT_NONE && irq_cond == 6'h00 |=> !int_pin_q)
        else $error("unlatched pin held");
    perm_hold_a: assert property (
        lat_q == LAT_PERM && int_pin_q && !req.rd && !(ctl_wr && req.wdata[IRQ_RESET_BIT])
        |=> int_pin_q) else $error("latched pin dropped");
    clear_a: assert property (
        ctl_wr && req.wdata[IRQ_RESET_BIT] && irq_cond == 6'h00 |=> !int_pin_q)
        else $error("pin not cleared");
    timed_hold_a: assert property (
        lat_q inside {[3'b001:3'b110]} && $rose(int_pin_q) |-> int_pin_q [*8])
        else $error("timed latch too short");
    ic_analog_a: assert property (ic_on_q |-> analog_on_q)
        else $error("controller on while asleep");
endmodule

bind accsc_core accsc_core_props chk (.core_clk(core_clk), .reset(reset), .req(req),
    .smp(smp), .irq_cond(irq_cond), .rdata_q(rdata_q), .rvalid_q(rvalid_q),
    .int_pin_q(int_pin_q), .analog_on_q(analog_on_q), .ic_on_q(ic_on_q),
    .axis_en_q(axis_en_q), .range_q(range_q), .eng_cfg_q(eng_cfg_q), .filt_q(filt_q));

// ==== verification/accsc_host.sv ====
module accsc_host
    import accsc_pkg::*;
(
    input wire logic core_clk,
    input wire logic [7:0] rdata_q,
    input wire logic rvalid_q,
    output accsc_req_t req
);
    timeunit 1ns;
    timeprecision 1ps;
    initial req = {1'b0, 1'b0, 1'b0, 7'h7f, 8'hff};
    // idle address and data show the inverse of the last request
    task automatic put(input logic r, input logic w, input logic b, input logic [6:0] a,
        input logic [7:0] v);
        @(negedge core_clk);
        req <= {r, w, b, a, v};
        @(negedge core_clk);
        req <= {1'b0, 1'b0, 1'b0, ~a, ~v};
    endtask
    task automatic rd(input logic [6:0] a, input logic b, output logic [7:0] v);
        int n;
        put(1'b1, 1'b0, b, a, 8'h00);
        n = 0;
        while (rvalid_q !== 1'b1 && n < 4) begin
            @(negedge core_clk);
            n++;
        end
        v = (n < 4) ? rdata_q : 8'hxx;
    endtask
    task automatic wr(input logic [6:0] a, input logic [7:0] v);
        put(1'b0, 1'b1, 1'b0, a, v);
    endtask
endmodule

// ==== verification/test_accel_sensor_control_core.sv ====
module test_accel_sensor_control_core
    import accsc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [7:0] CHIP = 8'h96; // arbitrary value
    localparam logic [7:0] REV = 8'h69; // arbitrary value
    localparam logic [17:0] SV = {6'h1e, 6'h21, 6'h04};
    logic core_clk = 1'b0;
    logic reset = 1'b1;
    accsc_req_t req;
    accsc_smp_t smp = '0;
    logic [5:0] irq_cond = '0;
    logic [7:0] rdata_q, d;
    logic rvalid_q, int_pin_q, analog_on_q, ic_on_q;
    logic [2:0] axis_en_q;
    logic [1:0] range_q;
    logic [11:0] eng_en_q;
    logic [47:0] eng_cfg_q;
    accsc_smp_t filt_q;
    int n_errors = 0;
    int samples_checked = 0;
    int cyc = 0;
    int n;
`define CHK(act, exp) begin samples_checked++; if ((act) !== (exp)) begin n_errors++; \
    $display("FAIL t=%0t got=%h exp=%h", $time, act, exp); end end
    accsc_core #(.CYC_PER_US(1), .CHIP_IDENTIFIER_VAL(CHIP), .REV_ID_VAL(REV)) dut (
        .core_clk(core_clk), .reset(reset), .req(req), .smp(smp), .irq_cond(irq_cond),
        .irq_first(3'b100), .irq_sign(1'b1), .orient_code(3'b010), .rdata_q(rdata_q),
        .rvalid_q(rvalid_q), .int_pin_q(int_pin_q), .analog_on_q(analog_on_q),
        .ic_on_q(ic_on_q), .axis_en_q(axis_en_q), .range_q(range_q), .eng_en_q(eng_en_q),
        .eng_cfg_q(eng_cfg_q), .filt_q(filt_q));
    accsc_host host (.core_clk(core_clk), .rdata_q(rdata_q), .rvalid_q(rvalid_q), .req(req));
    initial begin
        forever #4 core_clk = ~core_clk;
    end
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 9000) begin
            n_errors++;
            stop_test();
        end
    end
    // ----
    // helpers
    // ----
    function automatic logic [7:0] half(input logic [5:0] v);
        logic signed [11:0] f;
        f = {v, 6'h00};
        f = f >>> 1;
        return {f[11:6], 2'b00};
    endfunction
    task automatic rd_chk(input logic [6:0] a, input logic [7:0] e);
        host.rd(a, 1'b0, d);
        `CHK(d, e)
    endtask
    task automatic send(input logic [17:0] v);
        @(negedge core_clk);
        smp <= {1'b1, v};
        @(negedge core_clk);
        smp <= {1'b0, ~v};
    endtask
    task automatic raise(input logic [5:0] c, input int k);
        @(negedge core_clk);
        irq_cond <= c;
        repeat (k) @(negedge core_clk);
        irq_cond <= 6'h00;
    endtask
    task automatic span(input logic ic, output int k);
        k = 0;
        // the power manager acts one edge after the register write lands
        @(negedge core_clk);
        while ((ic ? ic_on_q : analog_on_q) === 1'b0 && k < 5000) begin
            @(negedge core_clk);
            k++;
        end
    endtask
    task automatic stop_test();
        $display("checks %0d errors %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // ----
    // tests
    // ----
    initial begin
        repeat (8) @(negedge core_clk);
        reset = 1'b0;
        `CHK({axis_en_q, range_q, eng_en_q}, 17'h1c000)
        rd_chk(ADR_CHIP_IDENTIFIER, CHIP);
        rd_chk(ADR_REV_ID, REV);
        host.wr(ADR_CHIP_IDENTIFIER, 8'h00);
        rd_chk(ADR_CHIP_IDENTIFIER, CHIP);
        rd_chk(7'h14, 8'h00);
        host.wr(ADR_FILTER, 8'h01);
        send(SV);
        `CHK(filt_q.acc[2], 6'h0f)
        for (int r = 0; r < 2; r++) begin
            host.wr(ADR_FILTER, {r[0], 7'h01});
            for (int i = 0; i < 3; i++) begin
                host.rd(ADR_ACC_X, i != 0, d);
                `CHK(d, r ? {SV[17-6*i -: 6], 2'b00} : half(SV[17-6*i -: 6]))
            end
        end
        host.wr(ADR_AXIS_SLEEP, 8'h03);
        send({6'h0a, 6'h0b, 6'h0c});
        rd_chk(ADR_ACC_X, 8'h78);
        host.rd(7'h00, 1'b1, d);
        `CHK(d, 8'h2c)
        for (int r = 0; r < 4; r++) begin
            host.wr(ADR_RANGE, 8'(r));
            `CHK(range_q, r[1:0])
        end
        host.wr(ADR_ENG_EN, 8'ha5);
        host.wr(ADR_CFG_LO, 8'h12);
        `CHK({eng_en_q, eng_cfg_q[7:0]}, 20'h0a512)
        host.wr(ADR_AXIS_SLEEP, 8'h05);
        rd_chk(ADR_SOFT_RESET, RD_IDLE);
        `CHK({analog_on_q, range_q, axis_en_q}, 6'h07)
        `CHK({eng_en_q, eng_cfg_q}, {12'h000, RST_CFG})
        host.wr(ADR_RANGE, 8'h02);
        rd_chk(ADR_SOFT_RESET, RD_ACTIVE);
        rd_chk(ADR_RANGE, 8'h00);
        `CHK(analog_on_q, 1'b1)
        rd_chk(ADR_SUSPEND, RD_IDLE);
        `CHK({analog_on_q, ic_on_q}, 2'b00)
        host.wr(ADR_RANGE, 8'h01);
        rd_chk(ADR_SUSPEND, RD_ACTIVE);
        rd_chk(ADR_RANGE, 8'h00);
        `CHK({analog_on_q, ic_on_q}, 2'b11)
        host.wr(ADR_IRQ_CTL, 8'h80);
        raise(6'h02, 2);
        `CHK(int_pin_q, 1'b1)
        repeat (2) @(negedge core_clk);
        `CHK(int_pin_q, 1'b0)
        host.wr(ADR_IRQ_CTL, 8'hf0);
        for (int i = 0; i < 5; i++) begin
            raise(6'h01 << i, 2);
            repeat (20) @(negedge core_clk);
            `CHK(int_pin_q, 1'b1)
            rd_chk(ADR_IRQ_TYPE, 8'h01 << i);
            rd_chk(ADR_IRQ_INFO, 8'h29);
            host.wr(ADR_IRQ_CTL, 8'hf0);
            `CHK(int_pin_q, 1'b0)
        end
        host.wr(ADR_IRQ_CTL, 8'h90);
        raise(6'h01, 2);
        repeat (60) @(negedge core_clk);
        `CHK(int_pin_q, 1'b1)
        host.wr(ADR_IRQ_CTL, 8'h80);
        `CHK(int_pin_q, 1'b0)
        host.wr(ADR_AXIS_SLEEP, 8'h47);
        span(1'b0, n);
        `CHK(n >= 2000 && n <= 2003, 1'b1)
        span(1'b1, n);
        `CHK(n >= 940 && n <= 943, 1'b1)
        irq_cond <= 6'h01;
        send(18'h0);
        repeat (100) @(negedge core_clk);
        `CHK(analog_on_q, 1'b1)
        irq_cond <= 6'h00;
        repeat (6) @(negedge core_clk);
        `CHK({analog_on_q, ic_on_q}, 2'b00)
        host.wr(ADR_AXIS_SLEEP, 8'h07);
        @(negedge core_clk);
        `CHK({analog_on_q, ic_on_q}, 2'b11)
        stop_test();
    end
endmodule
